// file: rtl/timer_block.sv
// Three timer/counters with a classic Wishbone register port
`timescale 1ns/100ps
`default_nettype none
module timer_block
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer0_count_input_i,
  input wire logic timer1_count_input_i,
  input wire logic timer2_count_input_i,
  input wire logic capture_direction_pin_i,
  input wire logic external_interrupt_pin0_i,
  input wire logic external_interrupt_pin1_i,
  input wire logic timer0_service_ack_i,
  input wire logic timer1_service_ack_i,
  output logic timer0_overflow_o,
  output logic timer1_overflow_o,
  output logic timer2_request_o
);

  // ==========================================================================
  // State
  phase_t phase_reg, phase_next;
  logic [1:0] slow_reg;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] mode_reg;
  logic [7:0] clk_ctl_reg;
  logic [7:0] t0_low_reg, t0_low_next, t0_high_reg, t0_high_next;
  logic [7:0] t1_low_reg, t1_low_next, t1_high_reg, t1_high_next;
  logic [7:0] t2_ctl_reg, t2_ctl_next;
  logic [7:0] t2_mode_reg;
  logic [7:0] cap_low_reg, cap_low_next, cap_high_reg, cap_high_next;
  logic [7:0] t2_low_reg, t2_low_next, t2_high_reg, t2_high_next;
  logic ack_reg;
  logic [7:0] rd_byte_reg, rd_byte;
  logic t2_req_reg;

  // ==========================================================================
  // Machine-cycle phases: pins sampled at C4, counts move at C3
  always_comb
  begin
    case (phase_reg)
      PH_C1: phase_next = PH_C2;
      PH_C2: phase_next = PH_C3;
      PH_C3: phase_next = PH_C4;
      default: phase_next = PH_C1;
    endcase
  end

  wire mc_tick = (phase_reg == PH_C3);
  wire sample_tick = (phase_reg == PH_C4);
  wire slow_tick = mc_tick && (slow_reg == SLOW_MC_LAST);

  // ==========================================================================
  // Pin edge detection, one detector per count or capture pin
  wire [3:0] pins = {capture_direction_pin_i, timer2_count_input_i, timer1_count_input_i, timer0_count_input_i};
  logic [3:0] fall;

  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_fall
    pin_fall_detect u_fall
    (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sample_i(sample_tick),
      .pin_i(pins[g]),
      .fall_o(fall[g])
    );
  end

  // ==========================================================================
  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_go = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  wire [7:0] wdat = wb_dat_i[7:0];
  wire hit_ctl = (wb_adr_i == ADDR_W'(OFF_TIMER01_CONTROL));
  wire hit_mode = (wb_adr_i == ADDR_W'(OFF_TIMER01_MODE));
  wire hit_t0l = (wb_adr_i == ADDR_W'(OFF_TIMER0_LOW));
  wire hit_t0h = (wb_adr_i == ADDR_W'(OFF_TIMER0_HIGH));
  wire hit_t1l = (wb_adr_i == ADDR_W'(OFF_TIMER1_LOW));
  wire hit_t1h = (wb_adr_i == ADDR_W'(OFF_TIMER1_HIGH));
  wire hit_ck = (wb_adr_i == ADDR_W'(OFF_CLOCK_CONTROL));
  wire hit_t2c = (wb_adr_i == ADDR_W'(OFF_TIMER2_CONTROL));
  wire hit_t2m = (wb_adr_i == ADDR_W'(OFF_TIMER2_MODE));
  wire hit_capl = (wb_adr_i == ADDR_W'(OFF_TIMER2_CAPTURE_LOW));
  wire hit_caph = (wb_adr_i == ADDR_W'(OFF_TIMER2_CAPTURE_HIGH));
  wire hit_t2l = (wb_adr_i == ADDR_W'(OFF_TIMER2_LOW));
  wire hit_t2h = (wb_adr_i == ADDR_W'(OFF_TIMER2_HIGH));
  wire wr_ctl = wr_go & hit_ctl;
  wire wr_t0l = wr_go & hit_t0l;
  wire wr_t0h = wr_go & hit_t0h;
  wire wr_t1l = wr_go & hit_t1l;
  wire wr_t1h = wr_go & hit_t1h;
  wire wr_t2c = wr_go & hit_t2c;
  wire wr_capl = wr_go & hit_capl;
  wire wr_caph = wr_go & hit_caph;
  wire wr_t2l = wr_go & hit_t2l;
  wire wr_t2h = wr_go & hit_t2h;

  always_comb
  begin
    if (hit_ctl) rd_byte = ctl_reg;
    else if (hit_mode) rd_byte = mode_reg;
    else if (hit_t0l) rd_byte = t0_low_reg;
    else if (hit_t0h) rd_byte = t0_high_reg;
    else if (hit_t1l) rd_byte = t1_low_reg;
    else if (hit_t1h) rd_byte = t1_high_reg;
    else if (hit_ck) rd_byte = clk_ctl_reg;
    else if (hit_t2c) rd_byte = t2_ctl_reg;
    else if (hit_t2m) rd_byte = t2_mode_reg;
    else if (hit_capl) rd_byte = cap_low_reg;
    else if (hit_caph) rd_byte = cap_high_reg;
    else if (hit_t2l) rd_byte = t2_low_reg;
    else if (hit_t2h) rd_byte = t2_high_reg;
    else rd_byte = 8'h00;
  end

  // ==========================================================================
  // Timers 0 and 1: one step of the selected mode, {carry, high, low}
  function automatic logic [16:0] step01(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    case (m)
      MODE_13BIT: step01 = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16BIT: step01 = s16;
      MODE_RELOAD8: step01 = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default: step01 = {s8[8], hi, s8[7:0]};
    endcase
  endfunction : step01

  wire [1:0] mode0 = mode_reg[MOD_SEL0_LSB +: 2];
  wire [1:0] mode1 = mode_reg[MOD_SEL1_LSB +: 2];
  wire t0_split = (mode0 == MODE_SPLIT);
  wire base0 = clk_ctl_reg[CK_TIMER0_TURBO] ? mc_tick : slow_tick;
  wire base1 = clk_ctl_reg[CK_TIMER1_TURBO] ? mc_tick : slow_tick;
  wire base2 = clk_ctl_reg[CK_TIMER2_TURBO] ? mc_tick : slow_tick;
  wire tick0 = mode_reg[MOD_FUNC0] ? (fall[0] & mc_tick) : base0;
  wire tick1 = mode_reg[MOD_FUNC1] ? (fall[1] & mc_tick) : base1;
  wire gate0_ok = ~mode_reg[MOD_GATE0] | external_interrupt_pin0_i;
  wire gate1_ok = ~mode_reg[MOD_GATE1] | external_interrupt_pin1_i;
  wire en0 = ctl_reg[CTL_RUN0] & gate0_ok & tick0;
  wire en0_high = t0_split & ctl_reg[CTL_RUN1] & base0;
  wire run1 = (t0_split | ctl_reg[CTL_RUN1]) & gate1_ok;
  wire en1 = run1 & tick1 & (mode1 != MODE_SPLIT);
  wire [16:0] st0 = step01(mode0, t0_high_reg, t0_low_reg);
  wire [16:0] st1 = step01(mode1, t1_high_reg, t1_low_reg);
  wire [8:0] t0_high_inc = {1'b0, t0_high_reg} + 9'h001;
  wire ovf0 = en0 & st0[16];
  wire ovf1 = (en0_high & t0_high_inc[8]) | (en1 & st1[16] & ~t0_split);

  assign t0_low_next = wr_t0l ? wdat : (en0 ? st0[7:0] : t0_low_reg);
  assign t0_high_next = wr_t0h ? wdat : en0_high ? t0_high_inc[7:0] :
                        (en0 & ~t0_split) ? st0[15:8] : t0_high_reg;
  assign t1_low_next = wr_t1l ? wdat : (en1 ? st1[7:0] : t1_low_reg);
  assign t1_high_next = wr_t1h ? wdat : (en1 ? st1[15:8] : t1_high_reg);

  // Hardware set wins over a clear by write or by service acknowledge
  always_comb
  begin
    ctl_next = wr_ctl ? (wdat & CTL_WRITE_MASK) : ctl_reg;
    if (timer0_service_ack_i) ctl_next[CTL_OVERFLOW0] = 1'b0;
    if (timer1_service_ack_i) ctl_next[CTL_OVERFLOW1] = 1'b0;
    if (ovf0) ctl_next[CTL_OVERFLOW0] = 1'b1;
    if (ovf1) ctl_next[CTL_OVERFLOW1] = 1'b1;
  end

  // ==========================================================================
  // Timer 2
  wire baud = t2_ctl_reg[T2C_RX_CLOCK] | t2_ctl_reg[T2C_TX_CLOCK];
  wire cap_mode = ~baud & t2_ctl_reg[T2C_CAPTURE_RELOAD];
  wire updown = ~baud & ~cap_mode & t2_mode_reg[T2M_UP_DOWN];
  wire tick2 = t2_ctl_reg[T2C_CLOCK_SELECT] ? (fall[2] & mc_tick) : base2;
  wire en2 = t2_ctl_reg[T2C_RUN] & tick2;
  wire ext2 = t2_ctl_reg[T2C_EXT_ENABLE] & fall[3] & mc_tick;
  wire [15:0] cnt2 = {t2_high_reg, t2_low_reg};
  wire [15:0] rcap = {cap_high_reg, cap_low_reg};
  wire [15:0] cnt2_inc = cnt2 + 16'h0001;
  wire [15:0] cnt2_dec = cnt2 - 16'h0001;
  wire wrap2 = (cnt2 == CNT16_MAX);
  wire at_cap = (cnt2 == rcap);
  logic [15:0] cnt2_calc;
  logic cap_load, tf2_set, external_event_flag_set, external_event_flag_tgl;

  always_comb
  begin
    cnt2_calc = cnt2;
    cap_load = 1'b0;
    tf2_set = 1'b0;
    external_event_flag_set = 1'b0;
    external_event_flag_tgl = 1'b0;
    if (baud)
    begin
      if (en2) cnt2_calc = wrap2 ? rcap : cnt2_inc;
      external_event_flag_set = ext2;
    end
    else if (cap_mode)
    begin
      if (en2) cnt2_calc = cnt2_inc;
      tf2_set = en2 & wrap2;
      if (ext2)
      begin
        cap_load = 1'b1;
        external_event_flag_set = 1'b1;
        if (t2_mode_reg[T2M_CAPTURE_CLEAR]) cnt2_calc = 16'h0000;
      end
    end
    else if (!updown)
    begin
      if (en2) cnt2_calc = wrap2 ? rcap : cnt2_inc;
      tf2_set = en2 & wrap2;
      if (ext2)
      begin
        cnt2_calc = rcap;
        external_event_flag_set = 1'b1;
      end
    end
    else if (en2)
    begin
      if (capture_direction_pin_i)
      begin
        cnt2_calc = wrap2 ? rcap : cnt2_inc;
        tf2_set = wrap2;
        external_event_flag_tgl = wrap2;
      end
      else
      begin
        cnt2_calc = at_cap ? CNT16_MAX : cnt2_dec;
        tf2_set = at_cap;
        external_event_flag_tgl = at_cap;
      end
    end
  end

  assign t2_low_next = wr_t2l ? wdat : cnt2_calc[7:0];
  assign t2_high_next = wr_t2h ? wdat : cnt2_calc[15:8];
  assign cap_low_next = wr_capl ? wdat : (cap_load ? t2_low_reg : cap_low_reg);
  assign cap_high_next = wr_caph ? wdat : (cap_load ? t2_high_reg : cap_high_reg);

  // Flags leave by software write, or for the external flag by toggle; hardware set or toggle wins
  always_comb
  begin
    t2_ctl_next = wr_t2c ? wdat : t2_ctl_reg;
    if (external_event_flag_tgl) t2_ctl_next[T2C_EXT_FLAG] = ~t2_ctl_next[T2C_EXT_FLAG];
    if (external_event_flag_set) t2_ctl_next[T2C_EXT_FLAG] = 1'b1;
    if (tf2_set) t2_ctl_next[T2C_OVERFLOW] = 1'b1;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= PH_C1;
      slow_reg <= 2'd0;
      ack_reg <= 1'b0;
      rd_byte_reg <= REG_RESET;
      t2_req_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      if (mc_tick) slow_reg <= (slow_reg == SLOW_MC_LAST) ? 2'd0 : slow_reg + 2'd1;
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) rd_byte_reg <= rd_byte;
      t2_req_reg <= t2_ctl_reg[T2C_OVERFLOW] | (t2_ctl_reg[T2C_EXT_FLAG] & ~updown);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_reg <= REG_RESET;
      mode_reg <= REG_RESET;
      clk_ctl_reg <= REG_RESET;
      t0_low_reg <= REG_RESET;
      t0_high_reg <= REG_RESET;
      t1_low_reg <= REG_RESET;
      t1_high_reg <= REG_RESET;
      t2_ctl_reg <= REG_RESET;
      t2_mode_reg <= REG_RESET;
      cap_low_reg <= REG_RESET;
      cap_high_reg <= REG_RESET;
      t2_low_reg <= REG_RESET;
      t2_high_reg <= REG_RESET;
    end
    else
    begin
      ctl_reg <= ctl_next;
      if (wr_go & hit_mode) mode_reg <= wdat;
      if (wr_go & hit_ck) clk_ctl_reg <= wdat & CK_WRITE_MASK;
      if (wr_go & hit_t2m) t2_mode_reg <= wdat & T2M_WRITE_MASK;
      t0_low_reg <= t0_low_next;
      t0_high_reg <= t0_high_next;
      t1_low_reg <= t1_low_next;
      t1_high_reg <= t1_high_next;
      t2_ctl_reg <= t2_ctl_next;
      cap_low_reg <= cap_low_next;
      cap_high_reg <= cap_high_next;
      t2_low_reg <= t2_low_next;
      t2_high_reg <= t2_high_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {24'h000000, rd_byte_reg};
  assign timer0_overflow_o = ctl_reg[CTL_OVERFLOW0];
  assign timer1_overflow_o = ctl_reg[CTL_OVERFLOW1];
  assign timer2_request_o = t2_req_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_count_at_c3;
    (!wr_t0l && t0_low_next != t0_low_reg) |-> mc_tick;
  endproperty
  a_count_at_c3: assert property (p_count_at_c3) else $error("timer 0 moved outside C3");

  property p_mode0_wrap;
    (en0 && mode0 == MODE_13BIT && {t0_high_reg, t0_low_reg[4:0]} == CNT13_MAX && !wr_t0l && !wr_t0h)
      |=> (t0_high_reg == 8'h00 && t0_low_reg[4:0] == 5'h00 && ctl_reg[CTL_OVERFLOW0]);
  endproperty
  a_mode0_wrap: assert property (p_mode0_wrap) else $error("13-bit wrap wrong");

  property p_reload8;
    (en0 && mode0 == MODE_RELOAD8 && t0_low_reg == CNT8_MAX && !wr_t0l && !wr_t0h)
      |=> (t0_low_reg == $past(t0_high_reg) && $stable(t0_high_reg));
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit reload wrong");

  property p_run_gate;
    (!ctl_reg[CTL_RUN0] && !wr_t0l) |=> $stable(t0_low_reg);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("timer 0 counted while stopped");

  property p_t1_frozen;
    (mode1 == MODE_SPLIT && !wr_t1l && !wr_t1h) |=> ($stable(t1_low_reg) && $stable(t1_high_reg));
  endproperty
  a_t1_frozen: assert property (p_t1_frozen) else $error("timer 1 moved in mode 3");

  property p_capture;
    (ext2 && cap_mode && !wr_capl && !wr_caph && !wr_t2c) |=> (rcap == $past(cnt2) && t2_ctl_reg[T2C_EXT_FLAG]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_capture_clear;
    (ext2 && cap_mode && t2_mode_reg[T2M_CAPTURE_CLEAR] && !wr_t2l && !wr_t2h) |=> (cnt2 == 16'h0000);
  endproperty
  a_capture_clear: assert property (p_capture_clear) else $error("capture clear missed");

  property p_down_load;
    (en2 && updown && !capture_direction_pin_i && at_cap && !wr_t2l && !wr_t2h && !wr_t2c)
      |=> (cnt2 == CNT16_MAX && t2_ctl_reg[T2C_OVERFLOW] && t2_ctl_reg[T2C_EXT_FLAG] != $past(t2_ctl_reg[T2C_EXT_FLAG]));
  endproperty
  a_down_load: assert property (p_down_load) else $error("down reload wrong");

  property p_baud_no_flag;
    (baud && en2 && wrap2 && !wr_t2c && !t2_ctl_reg[T2C_OVERFLOW] && !wr_t2l && !wr_t2h)
      |=> (!t2_ctl_reg[T2C_OVERFLOW] && cnt2 == $past(rcap));
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud wrap wrong");

  property p_service_clear;
    (timer0_service_ack_i && !ovf0) |=> !ctl_reg[CTL_OVERFLOW0];
  endproperty
  a_service_clear: assert property (p_service_clear) else $error("overflow flag not cleared");

endmodule : timer_block
`default_nettype wire

// file: inc/timer_pkg.sv
// Constants shared by the three-timer block: offsets, fields, resets, timing
// Summary of operation
// - Count pin sampled each machine cycle; high-then-low counts
// - Edge takes two cycles; count updates one later
// - Mode bit 2 / bit 6 picks timer or counter
// - Timer base clock/12, or clock/4 when turbo set
// - Mode 0: high byte plus five low bits
// - Mode 0 wraps 1FFFh to 0000h, sets overflow
// - Count only when run set and gate allows
// - Mode 1: full 16 bits, overflow on FFFFh wrap
// - Mode 2: low byte reloads from high on wrap
// - Timer 1 in mode 3 holds its count
// - Timer 0 mode 3: two bytes, high uses timer-1 controls
// - Then timer 1 runs ungated by run bit, no flag
// - Timer 2 clock: pin or divided clock, run bit gates
// - Capture mode counts up, overflow flag on wrap
// - Pin fall captures count, sets external flag
// - Capture-clear bit zeroes timer 2 after capture
// - Up reload mode reloads from capture on wrap
// - Pin fall also reloads, sets external flag
// - Up/down mode counts up while pin high
// - Down past capture value loads FFFFh; overflow set, external flag toggles
// - Baud mode reloads without overflow; pin sets external flag
// - Service acknowledge clears timer 0/1 overflow flags
// - Timer 2 overflow flag cleared only by software; external flag also toggles in up/down mode
package timer_pkg;

  // ==========================================================================
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_TIMER01_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TIMER01_MODE = 8'h04;
  localparam logic [7:0] OFF_TIMER0_LOW = 8'h08;
  localparam logic [7:0] OFF_TIMER0_HIGH = 8'h0C;
  localparam logic [7:0] OFF_TIMER1_LOW = 8'h10;
  localparam logic [7:0] OFF_TIMER1_HIGH = 8'h14;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h18;
  localparam logic [7:0] OFF_TIMER2_CONTROL = 8'h1C;
  localparam logic [7:0] OFF_TIMER2_MODE = 8'h20;
  localparam logic [7:0] OFF_TIMER2_CAPTURE_LOW = 8'h24;
  localparam logic [7:0] OFF_TIMER2_CAPTURE_HIGH = 8'h28;
  localparam logic [7:0] OFF_TIMER2_LOW = 8'h2C;
  localparam logic [7:0] OFF_TIMER2_HIGH = 8'h30;

  // ==========================================================================
  // Field positions
  localparam int CTL_OVERFLOW1 = 7;
  localparam int CTL_RUN1 = 6;
  localparam int CTL_OVERFLOW0 = 5;
  localparam int CTL_RUN0 = 4;
  localparam int MOD_GATE1 = 7;
  localparam int MOD_FUNC1 = 6;
  localparam int MOD_SEL1_LSB = 4;
  localparam int MOD_GATE0 = 3;
  localparam int MOD_FUNC0 = 2;
  localparam int MOD_SEL0_LSB = 0;
  localparam int CK_TIMER0_TURBO = 3;
  localparam int CK_TIMER1_TURBO = 4;
  localparam int CK_TIMER2_TURBO = 5;
  localparam int T2C_OVERFLOW = 7;
  localparam int T2C_EXT_FLAG = 6;
  localparam int T2C_RX_CLOCK = 5;
  localparam int T2C_TX_CLOCK = 4;
  localparam int T2C_EXT_ENABLE = 3;
  localparam int T2C_RUN = 2;
  localparam int T2C_CLOCK_SELECT = 1;
  localparam int T2C_CAPTURE_RELOAD = 0;
  localparam int T2M_CAPTURE_CLEAR = 3;
  localparam int T2M_UP_DOWN = 0;

  // ==========================================================================
  // Writable masks, reset value and count limits
  localparam logic [7:0] CTL_WRITE_MASK = 8'hF0;
  localparam logic [7:0] CK_WRITE_MASK = 8'h38;
  localparam logic [7:0] T2M_WRITE_MASK = 8'h09;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [12:0] CNT13_MAX = 13'h1FFF;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;
  localparam logic [7:0] CNT8_MAX = 8'hFF;

  // ==========================================================================
  // Timing: machine cycle of four clocks, slow base every third one
  localparam int TURBO_DIV = 4;
  localparam int SLOW_DIV = 12;
  localparam logic [1:0] SLOW_MC_LAST = 2'(SLOW_DIV / TURBO_DIV - 1);

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    MODE_13BIT = 2'd0,
    MODE_16BIT = 2'd1,
    MODE_RELOAD8 = 2'd2,
    MODE_SPLIT = 2'd3
  } count_mode_t;

  typedef enum logic [1:0] {
    PH_C1 = 2'b00,
    PH_C2 = 2'b01,
    PH_C3 = 2'b11,
    PH_C4 = 2'b10
  } phase_t;

endpackage : timer_pkg

// file: rtl/pin_fall_detect.sv
// Falling-edge detector for a pin sampled once per machine cycle
`timescale 1ns/100ps
`default_nettype none
module pin_fall_detect
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic pin_i,
  output logic fall_o
);

  logic prev_reg;
  logic fall_reg;

  // Result holds for a whole machine cycle so the update phase can see it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= 1'b0;
      fall_reg <= 1'b0;
    end
    else if (sample_i)
    begin
      prev_reg <= pin_i;
      fall_reg <= prev_reg & ~pin_i;
    end
  end

  assign fall_o = fall_reg;

endmodule : pin_fall_detect
`default_nettype wire

// file: dv/pulse_source.sv
// Far-side pin source: emits falling-edge pulses on a count or capture pin
`timescale 1ns/100ps
`default_nettype none
module pulse_source
(
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  output logic pin_o,
  output logic busy_o
);
  int n;
  initial
  begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (start_i)
      begin
        n = count_i;
        busy_o <= 1'b1;
        // Twelve clocks high, twelve low: at most one fall per 24 clocks
        repeat (n)
        begin
          pin_o <= 1'b1;
          repeat (12) @(posedge clk_i);
          pin_o <= 1'b0;
          repeat (12) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : pulse_source
`default_nettype wire

// file: dv/dual_basic_and_capture_timers_test.sv
// Self-checking bench for the three-timer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("Error %0t: got %h want %h", $time, a, b); end end
module dual_basic_and_capture_timers_test
  import timer_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, ovf0, ovf1, req2;
  logic [3:0] start = 4'h0;
  logic [3:0] pins, busy;
  logic [1:0] gate = 2'b00;
  logic [1:0] sack = 2'b00;
  logic [7:0] npulse = 8'h00;
  logic [31:0] rnd = 32'hF6C443A8;
  int errors = 0;
  int samples_checked = 0;
  int exp16;

  always #20 clk_i = ~clk_i;

  timer_block i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer0_count_input_i(pins[0]), .timer1_count_input_i(pins[1]), .timer2_count_input_i(pins[2]),
    .capture_direction_pin_i(pins[3]), .external_interrupt_pin0_i(gate[0]),
    .external_interrupt_pin1_i(gate[1]), .timer0_service_ack_i(sack[0]), .timer1_service_ack_i(sack[1]),
    .timer0_overflow_o(ovf0), .timer1_overflow_o(ovf1), .timer2_request_o(req2));

  pulse_source u_src[3:0] (.clk_i(clk_i), .start_i(start), .count_i(npulse), .pin_o(pins), .busy_o(busy));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20)
    begin
      errors++;
      wrap_up();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic pulse(input int idx, input logic [7:0] n);
    int k;
    k = 0;
    @(posedge clk_i);
    npulse <= n;
    start[idx] <= 1'b1;
    @(posedge clk_i);
    start[idx] <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (busy[idx] !== 1'b0 && k < 1000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 1000)
    begin
      errors++;
      wrap_up();
    end
    repeat (16) @(posedge clk_i);
  endtask : pulse

  task automatic service(input int idx);
    @(posedge clk_i);
    sack[idx] <= 1'b1;
    @(posedge clk_i);
    sack[idx] <= 1'b0;
    @(posedge clk_i);
  endtask : service

  initial
  begin
    repeat (100000) @(posedge clk_i);
    errors++;
    wrap_up();
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 8'h3C; a += 4)
    begin
      wb(1'b0, 8'(a), 8'h00);
      `CHK(rdat, 32'h0)
    end
    // Timer 1 counter, 16 bits, wraps past FFFFh
    rnd = lfsr(rnd);
    exp16 = {8'hFF, 5'h1F, rnd[2:0]};
    wb(1'b1, OFF_TIMER1_LOW, 8'(exp16));
    wb(1'b1, OFF_TIMER1_HIGH, 8'hFF);
    wb(1'b1, OFF_TIMER01_MODE, 8'h50);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h40);
    pulse(1, 8'd9);
    exp16 = exp16 + 9;
    `CHK(ovf1, 1'b1)
    wb(1'b0, OFF_TIMER1_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    wb(1'b0, OFF_TIMER1_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'(exp16 >> 8))
    service(1);
    `CHK(ovf1, 1'b0)
    wb(1'b1, OFF_TIMER01_MODE, 8'h70);
    pulse(1, 8'd3);
    wb(1'b0, OFF_TIMER1_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    // Timer 0 counter, 13 bits, gated by its interrupt pin
    rnd = lfsr(rnd);
    wb(1'b1, OFF_TIMER0_LOW, {rnd[7:5], 5'h1F});
    wb(1'b1, OFF_TIMER0_HIGH, 8'hFF);
    wb(1'b1, OFF_TIMER01_MODE, 8'h0C);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h10);
    pulse(0, 8'd2);
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], {rnd[7:5], 5'h1F})
    gate[0] <= 1'b1;
    pulse(0, 8'd1);
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], {rnd[7:5], 5'h00})
    wb(1'b0, OFF_TIMER0_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'h00)
    `CHK(ovf0, 1'b1)
    service(0);
    // Timer 0 counter, 8-bit reload
    wb(1'b1, OFF_TIMER0_HIGH, rnd[15:8]);
    wb(1'b1, OFF_TIMER0_LOW, 8'hFF);
    wb(1'b1, OFF_TIMER01_MODE, 8'h06);
    pulse(0, 8'd1);
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], rnd[15:8])
    `CHK(ovf0, 1'b1)
    // Timer 2 capture, clocked from its pin
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h0F);
    rnd = lfsr(rnd);
    exp16 = rnd[2:0] + 1;
    pulse(2, 8'(exp16));
    pulse(3, 8'd1);
    `CHK(req2, 1'b1)
    wb(1'b0, OFF_TIMER2_CAPTURE_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    wb(1'b0, OFF_TIMER2_CONTROL, 8'h00);
    `CHK(rdat[7:0], 8'h4F)
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h0F);
    repeat (2) @(posedge clk_i);
    `CHK(req2, 1'b0)
    // Timer 0 as a timer: one count per 4 clocks in turbo, per 12 otherwise
    rnd = lfsr(rnd);
    exp16 = rnd[3:0] + 1;
    wb(1'b1, OFF_TIMER0_LOW, 8'h00);
    wb(1'b1, OFF_TIMER01_MODE, 8'h01);
    wb(1'b1, OFF_CLOCK_CONTROL, 8'h08);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h10);
    repeat (4 * exp16 - 3) @(posedge clk_i);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h00);
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    wb(1'b1, OFF_TIMER0_LOW, 8'h00);
    wb(1'b1, OFF_CLOCK_CONTROL, 8'h00);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h10);
    repeat (12 * exp16 - 3) @(posedge clk_i);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h00);
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    // Timer 0 split: high byte runs on timer 1's run bit, low byte stays
    wb(1'b1, OFF_TIMER0_HIGH, 8'h00);
    wb(1'b1, OFF_TIMER01_MODE, 8'h03);
    wb(1'b1, OFF_CLOCK_CONTROL, 8'h08);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h40);
    repeat (4 * exp16 - 3) @(posedge clk_i);
    wb(1'b1, OFF_TIMER01_CONTROL, 8'h00);
    wb(1'b0, OFF_TIMER0_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    wb(1'b0, OFF_TIMER0_LOW, 8'h00);
    `CHK(rdat[7:0], 8'(exp16))
    // Timer 2 baud-clock mode: reload without overflow flag
    rnd = lfsr(rnd);
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h16);
    wb(1'b1, OFF_TIMER2_CAPTURE_LOW, {1'b0, rnd[6:0]});
    wb(1'b1, OFF_TIMER2_CAPTURE_HIGH, rnd[15:8]);
    wb(1'b1, OFF_TIMER2_LOW, 8'hFE);
    wb(1'b1, OFF_TIMER2_HIGH, 8'hFF);
    pulse(2, 8'h03);
    wb(1'b0, OFF_TIMER2_LOW, 8'h00);
    `CHK(rdat[7:0], {1'b0, rnd[6:0]} + 8'h01)
    wb(1'b0, OFF_TIMER2_HIGH, 8'h00);
    `CHK(rdat[7:0], rnd[15:8])
    `CHK(req2, 1'b0)
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h1E);
    pulse(3, 8'h01);
    `CHK(req2, 1'b1)
    // Timer 2 up/down with direction pin low: down, then past capture value
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h06);
    wb(1'b1, OFF_TIMER2_MODE, 8'h01);
    wb(1'b1, OFF_TIMER2_LOW, {1'b0, rnd[6:0]} + 8'h01);
    wb(1'b1, OFF_TIMER2_HIGH, rnd[15:8]);
    pulse(2, 8'h02);
    wb(1'b0, OFF_TIMER2_LOW, 8'h00);
    `CHK(rdat[7:0], 8'hFF)
    wb(1'b0, OFF_TIMER2_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'hFF)
    wb(1'b0, OFF_TIMER2_CONTROL, 8'h00);
    `CHK(rdat[7:0], 8'hC6)
    `CHK(req2, 1'b1)
    // Capture with clear: count restarts from zero after the capture
    wb(1'b1, OFF_TIMER2_MODE, 8'h08);
    wb(1'b1, OFF_TIMER2_CONTROL, 8'h0F);
    pulse(3, 8'h01);
    wb(1'b0, OFF_TIMER2_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'h00)
    wb(1'b0, OFF_TIMER2_CAPTURE_HIGH, 8'h00);
    `CHK(rdat[7:0], 8'hFF)
    wrap_up();
  end
endmodule : dual_basic_and_capture_timers_test
`default_nettype wire
